// >>> tb/sfl_far_tx.sv
`timescale 1ns/1ps
module sfl_far_tx (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // frame control
  input wire logic active,
  input wire logic invert,
  input wire logic drop_mark,
  input wire logic [23:0] data,
  // line side
  output logic serial_bit,
  output logic [23:0] sent_data
);
  logic [27:0] sh;
  logic [27:0] f;
  logic [4:0] cnt;
  // frame image, data lsb first after the high mark
  always_comb begin
    f = 28'h0;
    f[0] = ~drop_mark;
    f[24:1] = invert ? ~data : data;
    f[26] = invert;
    f[25] = ^{f[26], f[24:1]};
  end
  // shifter, a released line toggles so stale bits never look valid
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_bit <= 1'b0;
      sh <= 28'h0;
      sent_data <= 24'h0;
      cnt <= 5'h0;
    end else if (!active) begin
      serial_bit <= ~serial_bit;
      cnt <= 5'h0;
    end else if (cnt == 5'h0) begin
      serial_bit <= f[0];
      sh <= f >> 1;
      sent_data <= data;
      cnt <= 5'h1b;
    end else begin
      serial_bit <= sh[0];
      sh <= sh >> 1;
      cnt <= cnt - 5'h1;
    end
  end
endmodule : sfl_far_tx

// >>> tb/tb.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin failures++; \
  $display("MISMATCH %s exp=%h got=%h", n, e, g); end end
module tb;
  import sfl_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic supply_good = 1'b0, txc = 1'b0, rxi, pready, pslverr, err, sop, son, soe;
  logic roe, rcoe, rclk, lock, lock_d, oe_all, oe_c1, fa = 1'b0, finv = 1'b0, fdrop = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [23:0] txd = 24'h0, txp, rxd, rxd_d, cur, fdat = 24'h0, fsent;
  logic [27:0] sh;
  logic [5:0] cv = 6'h0;
  int c = 0, k = 0, cyc = 0, drops = 0, failures = 0, check_count = 0;
  // device under test with a short transmit lock count
  sfl_serdes #(.TX_LOCK_EDGES(2), .RX_LOCK_FRAMES(4)) u_sfl_serdes (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .supply_good(supply_good), .tx_parallel_clock(txc),
    .tx_parallel_in(txd), .serial_out_p(sop), .serial_out_n(son), .serial_out_oe(soe),
    .serial_in_pair(rxi), .rx_parallel_out(rxd), .rx_parallel_oe(roe), .rx_clock_out(rclk),
    .rx_clock_oe(rcoe), .rx_lock(lock));
  // companion serializer on the receive pair
  sfl_far_tx u_sfl_far_tx (.pclk(pclk), .presetn(presetn), .active(fa), .invert(finv),
    .drop_mark(fdrop), .data(fdat), .serial_bit(rxi), .sent_data(fsent));
  initial begin
    forever #2.5 pclk = ~pclk;
  end
  // apb master, waits for pready
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task wr(input logic [5:0] v);
    apb(1'b1, ADDR_CTRL, {26'h0, v});
    cv <= v;
  endtask : wr
  // bounded wait on lock (s=0) or serial enable (s=1)
  task wt(input int s, input logic v, input int lim);
    int i;
    i = 0;
    while (i < lim && (s ? soe : lock) !== v) begin
      @(posedge pclk);
      i++;
    end
  endtask : wt
  task summarize;
    if (failures == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : summarize
  // tx clock of 28 cycles, random stimulus, frame decoder and rx monitors
  always @(posedge pclk) begin
    c <= (c == 27) ? 0 : c + 1;
    txc <= (c < 14) ? cv[2] : ~cv[2];
    fdat <= 24'($urandom);
    finv <= 1'($urandom);
    if (c == 0) begin
      txd <= (soe === 1'b1) ? 24'($urandom) : 24'h0;
      txp <= txd;
    end
    sh <= {sop, sh[27:1]};
    oe_c1 <= soe;
    oe_all <= (c == 2) ? (soe & oe_c1) : oe_all & soe;
    if (c == 2 && oe_all) begin
      `CHK("mark_hi", 1'b1, sh[POS_MARK_HIGH])
      `CHK("mark_lo", 1'b0, sh[POS_MARK_LOW])
      `CHK("integrity", 1'b0, ^sh[26:1])
      `CHK("tx_data", txp, sh[24:1] ^ {24{sh[POS_BALANCE]}})
    end
    if (soe === 1'b1) `CHK("out_n", ~sop, son)
    if (lock !== 1'b1) `CHK("rx_oe_off", 2'b00, {roe, rcoe})
    lock_d <= lock;
    rxd_d <= rxd;
    if (lock_d === 1'b1 && lock !== 1'b1) drops++;
    if (fsent !== cur) begin
      cur <= fsent;
    end
    if (lock === 1'b1 && (lock_d !== 1'b1 || rxd !== rxd_d)) `CHK("rx_data", cur, rxd)
    if (lock === 1'b1 && lock_d !== 1'b1) begin
      `CHK("rclk_rise", ~cv[5], rclk)
      `CHK("rx_oe_on", 2'b11, {roe, rcoe})
      k <= 14;
    end else if (k != 0) begin
      if (k == 1 && lock === 1'b1) `CHK("rclk_edge", cv[5], rclk)
      k <= k - 1;
    end
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc > 20000) begin
      failures++;
      summarize();
    end
  end
  initial begin
    void'($urandom(32'he552));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, ADDR_CTRL, 32'h0);
    `CHK("ctrl_rst", 32'h0, rd)
    apb(1'b1, ADDR_CTRL, 32'hffffffc0);
    apb(1'b0, ADDR_CTRL, 32'h0);
    `CHK("ctrl_rb", 32'h0, rd)
    apb(1'b0, 12'h008, 32'h0);
    `CHK("unmapped", 33'h100000000, {err, rd})
    apb(1'b1, ADDR_STATUS, 32'hffffffff);
    apb(1'b0, ADDR_STATUS, 32'h0);
    `CHK("status_rst", 33'h0, {err, rd & 32'hff03})
    wr(6'h07);
    repeat (200) @(posedge pclk);
    `CHK("no_supply", 1'b0, soe)
    supply_good <= 1'b1;
    wt(1, 1'b1, 300);
    `CHK("tx_up", 1'b1, soe)
    repeat (170) @(posedge pclk);
    wr(6'h06);
    repeat (3) @(posedge pclk);
    `CHK("tx_oe_off", 1'b0, soe)
    wr(6'h07);
    repeat (3) @(posedge pclk);
    `CHK("tx_resume", 1'b1, soe)
    repeat (140) @(posedge pclk);
    wr(6'h03);
    wt(1, 1'b1, 400);
    repeat (140) @(posedge pclk);
    wr(6'h01);
    repeat (3) @(posedge pclk);
    apb(1'b0, ADDR_STATUS, 32'h0);
    `CHK("tx_pd", 2'b00, {soe, rd[STAT_TX_LOCK]})
    wr(6'h03);
    wt(1, 1'b1, 400);
    `CHK("tx_relock", 1'b1, soe)
    fa <= 1'b1;
    wr(6'h1b);
    wt(0, 1'b1, 400);
    `CHK("rx_lock", 1'b1, lock)
    repeat (150) @(posedge pclk);
    fdrop <= 1'b1;
    repeat (28) @(posedge pclk);
    fdrop <= 1'b0;
    wt(0, 1'b0, 60);
    wt(0, 1'b1, 400);
    apb(1'b0, ADDR_STATUS, 32'h0);
    `CHK("relock", 10'h203, {lock, rd[15:8], rd[STAT_RX_LOCK]} )
    `CHK("drops", 1, drops)
    wr(6'h13);
    repeat (60) @(posedge pclk);
    `CHK("rx_oe_low", 3'b001, {roe, rcoe, lock})
    wr(6'h1b);
    repeat (3) @(posedge pclk);
    `CHK("rx_oe_back", 2'b11, {roe, rcoe})
    wr(6'h2b);
    repeat (3) @(posedge pclk);
    `CHK("rx_pd", 3'b000, {roe, rcoe, lock})
    wr(6'h3b);
    wt(0, 1'b1, 400);
    `CHK("rx_relock", 1'b1, lock)
    repeat (40) @(posedge pclk);
    fa <= 1'b0;
    wt(0, 1'b0, 60);
    `CHK("rx_loss", 1'b0, lock)
    fa <= 1'b1;
    wt(0, 1'b1, 400);
    `CHK("rx_again", 1'b1, lock)
    repeat (20) @(posedge pclk);
    summarize();
  end
endmodule : tb

// >>> verilog/sfl_pkg.sv
package sfl_pkg;
  // frame layout, first bit on the line is bit 0
  localparam int FRAME_BITS = 28;
  localparam int DATA_BITS = 24;
  localparam int POS_MARK_HIGH = 0;
  localparam int POS_DATA_LSB = 1;
  localparam int POS_INTEGRITY = 25;
  localparam int POS_BALANCE = 26;
  localparam int POS_MARK_LOW = 27;
  // recovered clock active edge sits half a frame after data launch
  localparam int RCLK_HALF = 14;
  // default lock criteria
  localparam int TX_LOCK_EDGES = 8;
  localparam int RX_LOCK_FRAMES = 4;
  // running disparity stays within one data field
  localparam int DISP_LIMIT = 24;
  // register map, byte addresses
  localparam int ADDR_W = 12;
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  // control register fields
  localparam int CTRL_W = 6;
  localparam int CTRL_TX_OE = 0;
  localparam int CTRL_TX_PD_N = 1;
  localparam int CTRL_TX_EDGE = 2;
  localparam int CTRL_RX_OE = 3;
  localparam int CTRL_RX_PD_N = 4;
  localparam int CTRL_RX_EDGE = 5;
  localparam logic [5:0] CTRL_RESET = 6'h00;
  // status register fields
  localparam int STAT_TX_LOCK = 0;
  localparam int STAT_RX_LOCK = 1;
  localparam int STAT_RX_HUNT = 2;
  localparam int STAT_LOSS_LSB = 8;
  // state machines
  typedef enum logic [1:0] {SFL_TX_OFF, SFL_TX_ACQUIRE, SFL_TX_RUN} sfl_tx_state_e;
  typedef enum logic [1:0] {SFL_RX_OFF, SFL_RX_HUNT, SFL_RX_TRACK, SFL_RX_LOCKED} sfl_rx_state_e;
endpackage : sfl_pkg

// >>> verilog/sfl_serdes.sv
// Contract
// - capture 24 input bits per transmit clock, edge picked by tx_edge_select.
// - each frame is 28 bits: 24 data, two marks, integrity, balance.
// - high mark always 1, low mark always 0, forming embedded clock edge.
// - balance bit tells if data is inverted to limit DC bias; receiver undoes it.
// - integrity bit generated every frame, checked by receiver during lock and run.
// - line carries 28 bits per transmit clock period.
// - serial output driven only with output enable and powerdown_n both high.
// - serial output stays off until supply good and transmit PLL locked.
// - until receive lock, parallel outputs and clock off, lock low.
// - receiver locks on random data; transmitter sends ordinary frames.
// - lock rises with the first valid recovered clock and data.
// - recovered clock synchronous to data, polarity by rx_edge_select.
// - edge select high launches for rising edge, low for falling edge.
// - one missing embedded clock edge drops lock and restarts the hunt.
// - transmit powerdown stops PLL, turns off output, relocks after.
// - receive powerdown stops PLL, turns off outputs, relocks before lock.
// - receive enable or powerdown low turns off data and clock, lock stays driven.
// - receive PLL keeps running while only output enable is low.
// - transmit enable back high resumes without relock if controls unchanged.
//
// The APB slave port and the register offsets were left to the implementer.
`timescale 1ns/1ps
module sfl_serdes #(
  parameter int TX_LOCK_EDGES = sfl_pkg::TX_LOCK_EDGES,
  parameter int RX_LOCK_FRAMES = sfl_pkg::RX_LOCK_FRAMES
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [sfl_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // transmit parallel side
  input wire logic supply_good,
  input wire logic tx_parallel_clock,
  input wire logic [sfl_pkg::DATA_BITS-1:0] tx_parallel_in,
  // transmit serial pair
  output logic serial_out_p,
  output logic serial_out_n,
  output logic serial_out_oe,
  // receive serial pair
  input wire logic serial_in_pair,
  // receive parallel side
  output logic [sfl_pkg::DATA_BITS-1:0] rx_parallel_out,
  output logic rx_parallel_oe,
  output logic rx_clock_out,
  output logic rx_clock_oe,
  output logic rx_lock
);
  import sfl_pkg::*;

  // parameter range checks at elaboration
  if (TX_LOCK_EDGES < 1 || TX_LOCK_EDGES > 255) begin : g_bad_tx_lock
    $error("TX_LOCK_EDGES out of range");
  end
  if (RX_LOCK_FRAMES < 1 || RX_LOCK_FRAMES > 255) begin : g_bad_rx_lock
    $error("RX_LOCK_FRAMES out of range");
  end

  // number of ones in a data field
  function automatic logic [4:0] ones(input logic [DATA_BITS-1:0] d);
    ones = '0;
    for (int i = 0; i < DATA_BITS; i++) begin
      ones = ones + 5'(d[i]);
    end
  endfunction : ones

  // marks in place and even parity over data, integrity and balance
  function automatic logic frame_ok(input logic [FRAME_BITS-1:0] f);
    frame_ok = f[POS_MARK_HIGH] & ~f[POS_MARK_LOW] & ~(^f[POS_BALANCE:POS_DATA_LSB]);
  endfunction : frame_ok

  // control register and apb answer
  logic [CTRL_W-1:0] ctrl, next_ctrl;
  logic [31:0] next_prdata;
  logic next_pslverr;
  logic apb_setup, apb_access;
  logic tx_oe, tx_pd_n, tx_edge, rx_oe, rx_pd_n, rx_edge;

  // transmit state
  sfl_tx_state_e tx_state, next_tx_state;
  logic tx_clk_prev, tx_edge_last, next_tx_edge_last;
  logic [7:0] tx_edges, next_tx_edges;
  logic [FRAME_BITS-1:0] tx_shift, next_tx_shift;
  logic [4:0] tx_left, next_tx_left;
  logic signed [7:0] tx_disp, next_tx_disp;
  logic signed [7:0] tx_d;
  logic tx_cap, tx_inv, tx_load;
  logic [DATA_BITS-1:0] tx_field;

  // receive state
  sfl_rx_state_e rx_state, next_rx_state;
  logic [FRAME_BITS-1:0] rx_sr, next_rx_sr;
  logic [4:0] rx_cnt, next_rx_cnt;
  logic [7:0] rx_good, next_rx_good;
  logic [7:0] rx_loss, next_rx_loss;
  logic [DATA_BITS-1:0] next_rx_data;
  logic next_rx_clock;
  logic rx_end;

  assign tx_oe = ctrl[CTRL_TX_OE];
  assign tx_pd_n = ctrl[CTRL_TX_PD_N];
  assign tx_edge = ctrl[CTRL_TX_EDGE];
  assign rx_oe = ctrl[CTRL_RX_OE];
  assign rx_pd_n = ctrl[CTRL_RX_PD_N];
  assign rx_edge = ctrl[CTRL_RX_EDGE];

  // apb decode, zero wait states, answer registered at setup
  assign apb_setup = psel & ~penable;
  assign apb_access = psel & penable;
  assign pready = apb_access;

  always_comb begin
    next_ctrl = ctrl;
    next_prdata = prdata;
    next_pslverr = pslverr;
    if (apb_access && pwrite && paddr == ADDR_CTRL) begin
      next_ctrl = pwdata[CTRL_W-1:0];
    end
    if (apb_setup) begin
      next_prdata = '0;
      next_pslverr = 1'b0;
      case (paddr)
        ADDR_CTRL: next_prdata[CTRL_W-1:0] = ctrl;
        ADDR_STATUS: begin
          next_prdata[STAT_TX_LOCK] = (tx_state == SFL_TX_RUN);
          next_prdata[STAT_RX_LOCK] = rx_lock;
          next_prdata[STAT_RX_HUNT] = (rx_state == SFL_RX_HUNT);
          next_prdata[STAT_LOSS_LSB +: 8] = rx_loss;
        end
        default: next_pslverr = 1'b1;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= CTRL_RESET;
      prdata <= '0;
      pslverr <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      prdata <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

  // transmit: capture edge, disparity choice, frame build
  assign tx_cap = tx_edge ? (tx_parallel_clock & ~tx_clk_prev) : (~tx_parallel_clock & tx_clk_prev);
  assign tx_d = 8'(signed'({2'b00, ones(tx_parallel_in), 1'b0})) - 8'sd24;
  assign tx_inv = (tx_disp > 0 && tx_d > 0) || (tx_disp < 0 && tx_d < 0);
  assign tx_field = tx_parallel_in ^ {DATA_BITS{tx_inv}};
  assign tx_load = (tx_state == SFL_TX_RUN) && tx_cap;

  always_comb begin
    next_tx_state = tx_state;
    next_tx_edges = tx_edges;
    next_tx_shift = {1'b0, tx_shift[FRAME_BITS-1:1]};
    next_tx_left = (tx_left == 5'd0) ? 5'd0 : tx_left - 5'd1;
    next_tx_disp = tx_disp;
    next_tx_edge_last = tx_edge;
    case (tx_state)
      SFL_TX_OFF: begin
        next_tx_state = SFL_TX_ACQUIRE;
        next_tx_edges = '0;
      end
      SFL_TX_ACQUIRE: begin
        if (tx_cap) begin
          if (tx_edges >= 8'(TX_LOCK_EDGES - 1)) begin
            next_tx_state = SFL_TX_RUN;
          end else begin
            next_tx_edges = tx_edges + 8'd1;
          end
        end
      end
      SFL_TX_RUN: begin
        // ordinary frames from the first locked edge on
        if (tx_cap) begin
          next_tx_shift = {1'b0, tx_inv, ^{tx_inv, tx_field}, tx_field, 1'b1};
          next_tx_left = 5'(FRAME_BITS - 1);
          next_tx_disp = tx_inv ? tx_disp - tx_d : tx_disp + tx_d;
        end
      end
      default: next_tx_state = SFL_TX_OFF;
    endcase
    // powerdown or low supply stop the pll; an edge change forces relock
    if (!supply_good || !tx_pd_n) begin
      next_tx_state = SFL_TX_OFF;
      next_tx_edges = '0;
    end else if (tx_edge != tx_edge_last && tx_state != SFL_TX_OFF) begin
      next_tx_state = SFL_TX_ACQUIRE;
      next_tx_edges = '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_state <= SFL_TX_OFF;
      tx_clk_prev <= 1'b0;
      tx_edge_last <= 1'b0;
      tx_edges <= '0;
      tx_shift <= '0;
      tx_left <= '0;
      tx_disp <= '0;
    end else begin
      tx_state <= next_tx_state;
      tx_clk_prev <= tx_parallel_clock;
      tx_edge_last <= next_tx_edge_last;
      tx_edges <= next_tx_edges;
      tx_shift <= next_tx_shift;
      tx_left <= next_tx_left;
      tx_disp <= next_tx_disp;
    end
  end

  // serial pair, off unless locked, enabled and powered
  assign serial_out_p = tx_shift[0];
  assign serial_out_n = ~tx_shift[0];
  assign serial_out_oe = (tx_state == SFL_TX_RUN) & tx_oe & tx_pd_n;

  // receive: hunt for a valid frame, track, then lock
  assign rx_end = (rx_cnt == 5'(FRAME_BITS - 1));

  always_comb begin
    next_rx_state = rx_state;
    next_rx_sr = {serial_in_pair, rx_sr[FRAME_BITS-1:1]};
    next_rx_cnt = rx_cnt;
    next_rx_good = rx_good;
    next_rx_loss = rx_loss;
    next_rx_data = rx_parallel_out;
    next_rx_clock = rx_clock_out;
    case (rx_state)
      SFL_RX_OFF: next_rx_state = SFL_RX_HUNT;
      SFL_RX_HUNT: begin
        // any data pattern: look for marks and parity at every bit offset
        if (frame_ok(next_rx_sr)) begin
          next_rx_state = SFL_RX_TRACK;
          next_rx_cnt = '0;
          next_rx_good = 8'd1;
        end
      end
      SFL_RX_TRACK, SFL_RX_LOCKED: begin
        next_rx_cnt = rx_end ? 5'd0 : rx_cnt + 5'd1;
        if (rx_end) begin
          if (frame_ok(next_rx_sr)) begin
            if (rx_state == SFL_RX_LOCKED || rx_good >= 8'(RX_LOCK_FRAMES - 1)) begin
              next_rx_state = SFL_RX_LOCKED;
              next_rx_data = next_rx_sr[POS_DATA_LSB +: DATA_BITS] ^ {DATA_BITS{next_rx_sr[POS_BALANCE]}};
              next_rx_clock = ~rx_edge;
            end else begin
              next_rx_good = rx_good + 8'd1;
            end
          end else begin
            // a single missing clock edge ends lock
            next_rx_state = SFL_RX_HUNT;
            next_rx_good = '0;
            if (rx_state == SFL_RX_LOCKED && rx_loss != 8'hff) begin
              next_rx_loss = rx_loss + 8'd1;
            end
          end
        end else if (rx_state == SFL_RX_LOCKED && rx_cnt == 5'(RCLK_HALF - 1)) begin
          next_rx_clock = rx_edge;
        end
      end
      default: next_rx_state = SFL_RX_OFF;
    endcase
    // powerdown stops the pll; output enable alone does not
    if (!rx_pd_n) begin
      next_rx_state = SFL_RX_OFF;
      next_rx_good = '0;
      next_rx_cnt = '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_state <= SFL_RX_OFF;
      rx_sr <= '0;
      rx_cnt <= '0;
      rx_good <= '0;
      rx_loss <= '0;
      rx_parallel_out <= '0;
      rx_clock_out <= 1'b0;
    end else begin
      rx_state <= next_rx_state;
      rx_sr <= next_rx_sr;
      rx_cnt <= next_rx_cnt;
      rx_good <= next_rx_good;
      rx_loss <= next_rx_loss;
      rx_parallel_out <= next_rx_data;
      rx_clock_out <= next_rx_clock;
    end
  end

  // lock always driven; data and clock only when locked and enabled
  assign rx_lock = (rx_state == SFL_RX_LOCKED);
  assign rx_parallel_oe = rx_lock & rx_oe & rx_pd_n;
  assign rx_clock_oe = rx_parallel_oe;

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_TX_MARKS: assert property (tx_load |=> tx_shift[POS_MARK_HIGH] && !tx_shift[POS_MARK_LOW])
    else $error("frame marks wrong");
  AST_TX_PARITY: assert property (tx_load |=> !(^tx_shift[POS_BALANCE:POS_DATA_LSB]))
    else $error("integrity bit wrong");
  AST_TX_RATE: assert property (tx_load |=> tx_left == 5'(FRAME_BITS - 1))
    else $error("frame length wrong");
  AST_TX_FRAME_END: assert property (tx_left == 5'd1 && !tx_load |=> !serial_out_p)
    else $error("frame not closed after its last bit");
  AST_TX_DISP: assert property (int'(tx_disp) <= DISP_LIMIT && int'(tx_disp) >= -DISP_LIMIT)
    else $error("running disparity out of bound");
  AST_TX_HIZ: assert property (!(tx_oe && tx_pd_n) |-> !serial_out_oe)
    else $error("serial driven while disabled");
  AST_TX_POWERON: assert property (!supply_good |=> !serial_out_oe ##1 !serial_out_oe)
    else $error("serial driven before supply good");
  AST_RX_HIZ: assert property (!rx_lock |-> !rx_parallel_oe && !rx_clock_oe)
    else $error("outputs driven without lock");
  AST_RX_LOCK_DATA: assert property ($rose(rx_lock) |-> rx_clock_out == !$past(rx_edge) && $past(rx_end))
    else $error("lock not aligned to first data");
  AST_RX_EDGE: assert property (rx_lock && !rx_end && rx_cnt == 5'(RCLK_HALF - 1) && rx_pd_n
    |=> rx_clock_out == $past(rx_edge))
    else $error("recovered clock edge wrong");
  AST_RX_RESYNC: assert property (rx_lock && rx_end && !frame_ok(next_rx_sr) && rx_pd_n
    |=> !rx_lock && rx_state == SFL_RX_HUNT)
    else $error("lock kept after missing edge");
  AST_RX_PD: assert property (!rx_pd_n |=> !rx_lock)
    else $error("lock high in powerdown");
  AST_RX_OE: assert property (rx_lock && !rx_oe && rx_pd_n && !rx_end && !(apb_access && pwrite)
    |=> rx_lock && !rx_parallel_oe)
    else $error("lock lost on output disable");
endmodule : sfl_serdes
